// *** hw/gcer_pkg.sv ***
package gcer_pkg;

  // ==========================================================================
  // Configuration space addresses
  // ==========================================================================
  localparam logic [7:0]  GCER_CTRL_OFFSET     = 8'h86;   // General control, 16 bits
  localparam logic [7:0]  GCER_STS_OFFSET      = 8'h88;   // Event status, 8 bits
  localparam logic [7:0]  GCER_EN_OFFSET       = 8'h89;   // Event enable, 8 bits
  localparam logic [7:0]  GCER_IO_BASE0_OFFSET = 8'h2C;   // I/O base window 0
  localparam logic [7:0]  GCER_IO_BASE1_OFFSET = 8'h34;   // I/O base window 1
  localparam logic [7:0]  GCER_IO_LIM0_OFFSET  = 8'h30;   // I/O limit window 0
  localparam logic [7:0]  GCER_IO_LIM1_OFFSET  = 8'h38;   // I/O limit window 1

  // ==========================================================================
  // General control fields
  // ==========================================================================
  localparam int          GCER_CTRL_ARB_LSB    = 0;       // Bus priority field, bits 1:0
  localparam int          GCER_CTRL_CARD_OFF   = 7;       // Card function off
  localparam int          GCER_CTRL_SW_TYPE    = 10;      // Power switch type
  localparam int          GCER_CTRL_IO_BASE    = 11;      // Force I/O base bit 0
  localparam int          GCER_CTRL_IO_LIMIT   = 12;      // Force I/O limit bit 0
  localparam int          GCER_CTRL_CARD_IF    = 14;      // Card interface choice
  localparam logic [15:0] GCER_CTRL_RESET      = 16'h0003; // Control reset value
  localparam logic [15:0] GCER_CTRL_GLOBAL_MSK = 16'h5C84; // Bits kept over host reset

  // ==========================================================================
  // Event status and enable fields
  // ==========================================================================
  localparam int          GCER_EVT_POWER       = 7;       // Power change flag
  localparam int          GCER_EVT_VPP12       = 6;       // High programming voltage flag
  localparam int          GCER_EVT_INPUTS      = 5;       // Number of input flags, bits 4:0
  localparam logic [7:0]  GCER_EVT_MASK        = 8'hDF;   // Bit 5 is always zero
  localparam logic [7:0]  GCER_EVT_RESET       = 8'h00;   // Status and enable reset value

  // ==========================================================================
  // Terminal routing and timing
  // ==========================================================================
  localparam logic [3:0]  GCER_ROUTE_GPI       = 4'h0;    // Routing code for general input
  localparam logic [1:0]  GCER_SETTLE_CYCLES   = 2'h3;    // Ignore input changes after reset

  // ==========================================================================
  // Bus priority policies
  // ==========================================================================
  typedef enum logic [1:0] {
    GCER_ARB_HOST_1394 = 2'h0,                             // Favour 1394 host function
    GCER_ARB_CARD      = 2'h1,                             // Favour card socket function
    GCER_ARB_RESERVED  = 2'h2,                             // Reserved code
    GCER_ARB_ROUND     = 2'h3                              // Fair round robin
  } gcer_arb_t;

endpackage : gcer_pkg

// *** hw/gcer_sync.sv ***
`timescale 1ns/1ps
module gcer_sync #(
  parameter int         WIDTH     = 1,                     // Number of bits
  parameter logic [0:0] RESET_VAL = 1'h0                   // Value of all bits at reset
) (
  input  wire logic             ref_clk,                   // System clock
  input  wire logic             arst_n,                    // Asynchronous reset
  input  wire logic [WIDTH-1:0] din,                       // Asynchronous level in
  output logic      [WIDTH-1:0] dout                       // Synchronised level
);

  // ==========================================================================
  // Two flop chain
  // ==========================================================================
  logic [WIDTH-1:0] stage1;                                // First flop, read only by dout
  logic [WIDTH-1:0] next_stage1;                           // Next first flop
  logic [WIDTH-1:0] next_dout;                             // Next second flop

  // Next values: shift along the chain
  always_comb begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  // Register the chain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= {WIDTH{RESET_VAL}};
      dout   <= {WIDTH{RESET_VAL}};
    end else begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end

endmodule : gcer_sync

// *** hw/gcer_input_events.sv ***
`timescale 1ns/1ps
module gcer_input_events (
  input  wire logic        ref_clk,                        // System clock
  input  wire logic        arst_n,                         // Global reset
  input  wire logic [4:0]  level,                          // Synchronised input levels
  input  wire logic [19:0] route,                          // Four-bit routing code per input
  output logic      [4:0]  change                          // One-cycle change pulses
);

  // ==========================================================================
  // Routing decode
  // ==========================================================================
  // True when a routing field selects the general input function
  function automatic logic gcer_is_input(input logic [3:0] code);
    gcer_is_input = (code == gcer_pkg::GCER_ROUTE_GPI);
  endfunction : gcer_is_input

  // ==========================================================================
  // Previous level and settle counter
  // ==========================================================================
  logic [4:0] prev;                                        // Level one cycle ago
  logic [1:0] settle;                                      // Cycles since reset release
  logic [4:0] next_prev;                                   // Next previous level
  logic [1:0] next_settle;                                 // Next settle count
  logic       primed;                                      // Chain holds real levels

  assign primed = (settle == gcer_pkg::GCER_SETTLE_CYCLES);

  // Next values and change detection, gated by routing
  always_comb begin
    next_prev   = level;
    next_settle = primed ? settle : settle + 2'h1;
    for (int i = 0; i < 5; i++) begin
      change[i] = primed && (level[i] != prev[i])
                  && gcer_is_input(route[4*i +: 4]);
    end
  end

  // Register the state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev   <= 5'h00;
      settle <= 2'h0;
    end else begin
      prev   <= next_prev;
      settle <= next_settle;
    end
  end

endmodule : gcer_input_events

// *** hw/gcer_regs.sv ***
`timescale 1ns/1ps
module gcer_regs (
  input  wire logic        ref_clk,                        // Host bus clock, 125 MHz
  input  wire logic        arst_n,                         // Global reset, async, active low
  input  wire logic        host_reset_n,                   // Host bus reset pin, active low
  input  wire logic        cfg_wr,                         // Config write strobe, one cycle
  input  wire logic        cfg_rd,                         // Config read strobe, one cycle
  input  wire logic [7:0]  cfg_addr,                       // Config byte address
  input  wire logic [3:0]  cfg_be,                         // Byte enables of the dword
  input  wire logic [31:0] cfg_wdata,                      // Write data
  output logic      [31:0] cfg_rdata,                      // Read data, registered
  output logic             cfg_rvalid,                     // Read data valid, one cycle
  input  wire logic        sock_power_write,               // Software changed Vcc or Vpp state
  input  wire logic        sock_vpp12_change,              // Vpp request moved to or from 12 V
  input  wire logic        multi_terminal_5,               // Terminal feeding input 4
  input  wire logic        multi_terminal_4,               // Terminal feeding input 3
  input  wire logic        multi_terminal_2,               // Terminal feeding input 2
  input  wire logic        multi_terminal_1,               // Terminal feeding input 1
  input  wire logic        multi_terminal_0,               // Terminal feeding input 0
  input  wire logic [3:0]  route_terminal_5,               // Routing code of terminal 5
  input  wire logic [3:0]  route_terminal_4,               // Routing code of terminal 4
  input  wire logic [3:0]  route_terminal_2,               // Routing code of terminal 2
  input  wire logic [3:0]  route_terminal_1,               // Routing code of terminal 1
  input  wire logic [3:0]  route_terminal_0,               // Routing code of terminal 0
  output logic      [1:0]  bus_priority_policy,            // Raw priority field
  output logic      [2:0]  arb_policy_onehot,              // 1394, card, round robin
  output logic             card_interface_choice,          // 0 payment style, 1 alternate
  output logic             card_function_off,              // Card function disabled
  output logic             card_access_en,                 // Card function usable
  output logic             power_switch_type,              // 0 low voltage, 1 12 V switch
  output logic             io_base_bit0,                   // Bit 0 of both I/O base regs
  output logic             io_limit_bit0,                  // Bit 0 of both I/O limit regs
  output logic             general_event_out               // General event, active high
);

  // ==========================================================================
  // Register address decode
  // ==========================================================================
  // A dword holds several
  // registers; byte
  // enables pick lanes.
  // Dword address that holds a given byte offset
  function automatic logic [7:0] gcer_dword(input logic [7:0] byte_addr);
    gcer_dword = {byte_addr[7:2], 2'h0};
  endfunction : gcer_dword

  // Byte lane of a byte offset within its dword
  function automatic logic [1:0] gcer_lane(input logic [7:0] byte_addr);
    gcer_lane = byte_addr[1:0];
  endfunction : gcer_lane

  logic hit_ctrl;                                          // Access to the control dword
  logic hit_evt;                                           // Access to the event dword

  assign hit_ctrl = (gcer_dword(cfg_addr) == gcer_dword(gcer_pkg::GCER_CTRL_OFFSET));
  assign hit_evt  = (gcer_dword(cfg_addr) == gcer_dword(gcer_pkg::GCER_STS_OFFSET));

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic       host_reset_sync_n;                           // Host reset in clock domain
  logic [4:0] term_sync;                                   // Terminal levels in clock domain
  logic [4:0] input_change;                                // Per-input change pulses

  // Pins are async: two
  // flops before use.
  // Routing codes share
  // this clock: none.
  // Host bus reset pin crosses into the clock domain
  gcer_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'h1)
  ) u_host_reset_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     (host_reset_n),
    .dout    (host_reset_sync_n)
  );

  // Terminal levels cross into the clock domain
  gcer_sync #(
    .WIDTH     (5),
    .RESET_VAL (1'h0)
  ) u_term_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .din     ({multi_terminal_5, multi_terminal_4, multi_terminal_2,
                multi_terminal_1, multi_terminal_0}),
    .dout    (term_sync)
  );

  // Changes count only
  // while routed as a
  // general input.
  // Change detection qualified by the routing of each terminal
  gcer_input_events u_input_events (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .level   (term_sync),
    .route   ({route_terminal_5, route_terminal_4, route_terminal_2,
                route_terminal_1, route_terminal_0}),
    .change  (input_change)
  );

  // ==========================================================================
  // General control register
  // ==========================================================================
  logic [15:0] general_control;                            // Control register
  logic [15:0] next_general_control;                       // Next control value
  logic [15:0] ctrl_wr_mask;                               // Bits written this cycle
  logic [15:0] ctrl_wr_data;                               // Write data aligned to control

  // Lanes 0 and 1 of this
  // dword are not ours.
  // Control lives in the upper half of its dword: lanes 2 and 3
  assign ctrl_wr_data = cfg_wdata[31:16];
  assign ctrl_wr_mask = {{8{cfg_wr && hit_ctrl && cfg_be[gcer_lane(gcer_pkg::GCER_CTRL_OFFSET) + 2'h1]}},
                         {8{cfg_wr && hit_ctrl && cfg_be[gcer_lane(gcer_pkg::GCER_CTRL_OFFSET)]}}};

  // Host reset is a level:
  // while seen low the
  // unmarked bits hold
  // reset and writes
  // are dropped. Marked
  // bits need global
  // reset to clear.
  // Next control value: host reset, then byte writes
  always_comb begin
    next_general_control = general_control;
    if (!host_reset_sync_n) begin
      // Host reset restores only the unmarked bits
      next_general_control = (general_control & gcer_pkg::GCER_CTRL_GLOBAL_MSK)
                           | (gcer_pkg::GCER_CTRL_RESET & ~gcer_pkg::GCER_CTRL_GLOBAL_MSK);
    end else begin
      // Every bit, reserved ones too, is stored as written
      next_general_control = (general_control & ~ctrl_wr_mask)
                           | (ctrl_wr_data & ctrl_wr_mask);
    end
  end

  // Async branch loads
  // constants only.
  // Register the control value; global reset loads all of it with GCER_CTRL_RESET
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      general_control <= gcer_pkg::GCER_CTRL_RESET;
    end else begin
      general_control <= next_general_control;
    end
  end

  // ==========================================================================
  // Event status and enable registers
  // ==========================================================================
  logic [7:0] general_event_status;                        // Sticky event flags
  logic [7:0] general_event_enable;                        // Per-flag enables
  logic [7:0] next_status;                                 // Next status value
  logic [7:0] next_enable;                                 // Next enable value
  logic [7:0] evt_set;                                     // Events raised this cycle
  logic [7:0] evt_clear;                                   // Write-one clear mask
  logic       sts_lane_wr;                                 // Status byte written
  logic       en_lane_wr;                                  // Enable byte written

  assign sts_lane_wr = cfg_wr && hit_evt && cfg_be[gcer_lane(gcer_pkg::GCER_STS_OFFSET)];
  assign en_lane_wr  = cfg_wr && hit_evt && cfg_be[gcer_lane(gcer_pkg::GCER_EN_OFFSET)];

  // Flags are sticky; a
  // set beats a clear so
  // no event is lost
  // between read and
  // its clear.
  // Next status and enable values
  always_comb begin
    evt_set                             = 8'h00;
    evt_set[gcer_pkg::GCER_EVT_POWER]   = sock_power_write;
    evt_set[gcer_pkg::GCER_EVT_VPP12]   = sock_vpp12_change;
    evt_set[gcer_pkg::GCER_EVT_INPUTS-1:0] = input_change;
    evt_clear = sts_lane_wr ? cfg_wdata[7:0] : 8'h00;
    // Set beats clear; bit 5 never holds a one
    next_status = ((general_event_status & ~evt_clear) | evt_set)
                & gcer_pkg::GCER_EVT_MASK;
    // Enable takes its byte as written, bit 5 dropped
    if (en_lane_wr) begin
      next_enable = cfg_wdata[15:8] & gcer_pkg::GCER_EVT_MASK;
    end else begin
      next_enable = general_event_enable;
    end
  end

  // All flag bits are
  // marked: only global
  // reset clears them.
  // Register flags; host reset leaves them alone
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      general_event_status <= gcer_pkg::GCER_EVT_RESET;
      general_event_enable <= gcer_pkg::GCER_EVT_RESET;
    end else begin
      general_event_status <= next_status;
      general_event_enable <= next_enable;
    end
  end

  // ==========================================================================
  // Control outputs
  // ==========================================================================
  logic [2:0] next_arb_onehot;                             // Decoded priority policy
  logic       next_event_out;                              // Next general event level

  // Reserved code is kept
  // as written but acts
  // as round robin.
  // Decode priority; reserved code falls back to round robin
  always_comb begin
    unique case (gcer_pkg::gcer_arb_t'(next_general_control[gcer_pkg::GCER_CTRL_ARB_LSB +: 2]))
      gcer_pkg::GCER_ARB_HOST_1394: next_arb_onehot = 3'h1;
      gcer_pkg::GCER_ARB_CARD:      next_arb_onehot = 3'h2;
      gcer_pkg::GCER_ARB_RESERVED:  next_arb_onehot = 3'h4;
      gcer_pkg::GCER_ARB_ROUND:     next_arb_onehot = 3'h4;
    endcase
    // Raised while any enabled flag is pending, dropped otherwise
    next_event_out = |(next_status & next_enable);
  end

  // Outputs load next
  // values: same edge as
  // the register.
  // Register every control output so it leaves straight from a flop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_priority_policy   <= gcer_pkg::GCER_CTRL_RESET[1:0];
      arb_policy_onehot     <= 3'h4;
      card_interface_choice <= 1'h0;
      card_function_off     <= 1'h0;
      card_access_en        <= 1'h1;
      power_switch_type     <= 1'h0;
      io_base_bit0          <= 1'h0;
      io_limit_bit0         <= 1'h0;
      general_event_out     <= 1'h0;
    end else begin
      bus_priority_policy   <= next_general_control[gcer_pkg::GCER_CTRL_ARB_LSB +: 2];
      arb_policy_onehot     <= next_arb_onehot;
      card_interface_choice <= next_general_control[gcer_pkg::GCER_CTRL_CARD_IF];
      card_function_off     <= next_general_control[gcer_pkg::GCER_CTRL_CARD_OFF];
      card_access_en        <= !next_general_control[gcer_pkg::GCER_CTRL_CARD_OFF];
      power_switch_type     <= next_general_control[gcer_pkg::GCER_CTRL_SW_TYPE];
      io_base_bit0          <= next_general_control[gcer_pkg::GCER_CTRL_IO_BASE];
      io_limit_bit0         <= next_general_control[gcer_pkg::GCER_CTRL_IO_LIMIT];
      general_event_out     <= next_event_out;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [31:0] next_rdata;                                 // Next read data
  logic        next_rvalid;                                // Next read valid

  // Zero while no answer
  // stands, so banks may
  // be OR-ed together.
  // Read mux; lanes outside this bank and unmapped dwords read zero
  always_comb begin
    next_rvalid = cfg_rd;
    next_rdata  = 32'h0000_0000;
    if (cfg_rd && hit_ctrl) begin
      next_rdata = {general_control, 16'h0000};
    end else if (cfg_rd && hit_evt) begin
      next_rdata = {16'h0000, general_event_enable, general_event_status};
    end
  end

  // One cycle latency,
  // one read per cycle.
  // Register the read answer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'h0;
    end else begin
      cfg_rdata  <= next_rdata;
      cfg_rvalid <= next_rvalid;
    end
  end

endmodule : gcer_regs

// *** tb/gcer_regs_props.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the control and event register bank
module gcer_regs_chk (
  input wire logic        ref_clk,               // Clock
  input wire logic        arst_n,                // Global reset
  input wire logic        host_reset_n,          // Host bus reset pin
  input wire logic        cfg_wr,                // Write strobe
  input wire logic        cfg_rd,                // Read strobe
  input wire logic [7:0]  cfg_addr,              // Byte address
  input wire logic [3:0]  cfg_be,                // Byte enables
  input wire logic [31:0] cfg_wdata,             // Write data
  input wire logic [31:0] cfg_rdata,             // Read data
  input wire logic        cfg_rvalid,            // Read answer
  input wire logic [1:0]  bus_priority_policy,   // Priority field
  input wire logic [2:0]  arb_policy_onehot,     // Decoded policy
  input wire logic        card_interface_choice, // Control bit 14
  input wire logic        card_function_off,     // Control bit 7
  input wire logic        card_access_en,        // Card usable
  input wire logic        power_switch_type,     // Control bit 10
  input wire logic        io_base_bit0,          // Control bit 11
  input wire logic        io_limit_bit0,         // Control bit 12
  input wire logic        general_event_out      // General event
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] hr_hist;                           // Recent host reset pin levels
  logic [3:0] next_hr_hist;                      // Next pin history
  logic       ctl_wr;                            // Control write while host reset idle
  // History keeps writes during a host reset out of the write checks
  always_comb begin
    next_hr_hist = {hr_hist[2:0], host_reset_n};
    ctl_wr = cfg_wr && (cfg_addr[7:2] == 6'h21) && host_reset_n && (&hr_hist);
  end
  // History register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hr_hist <= 4'h0;
    end else begin
      hr_hist <= next_hr_hist;
    end
  end
  a_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("read not answered next cycle");
  a_rdata_idle: assert property (!cfg_rvalid |-> cfg_rdata == 32'h0) else $error("read data not zero when idle");
  a_arb_decode: assert property (arb_policy_onehot == ((bus_priority_policy == 2'h0) ? 3'h1 :
    (bus_priority_policy == 2'h1) ? 3'h2 : 3'h4)) else $error("priority decode wrong");
  a_card_enable: assert property (card_access_en == !card_function_off) else $error("card enable mismatch");
  a_ctrl_upper: assert property (ctl_wr && cfg_be[3] |=> {card_interface_choice, io_limit_bit0, io_base_bit0,
    power_switch_type} == {$past(cfg_wdata[30]), $past(cfg_wdata[28:26])}) else $error("upper control wrong");
  a_card_off_wr: assert property (ctl_wr && cfg_be[2] |=> card_function_off == $past(cfg_wdata[23]))
    else $error("card off bit wrong");
  a_bit5_zero: assert property (cfg_rd && cfg_addr[7:2] == 6'h22 |=> !cfg_rdata[13] && !cfg_rdata[5])
    else $error("bit 5 not zero");
  a_event_fall: assert property ($fell(general_event_out) |-> $past(cfg_wr)) else $error("event dropped alone");
endmodule : gcer_regs_chk
bind gcer_regs gcer_regs_chk gcer_regs_chk_inst (.*);

// *** tb/gcer_regs_tb_top.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Bench top
module gcer_regs_tb_top;
  logic        ref_clk, arst_n, host_reset_n, cfg_wr, cfg_rd, sock_power_write, sock_vpp12_change; // Drives
  logic        multi_terminal_5, multi_terminal_4, multi_terminal_2, multi_terminal_1, multi_terminal_0; // Pins
  logic [3:0]  route_terminal_5, route_terminal_4, route_terminal_2, route_terminal_1, route_terminal_0; // Routes
  logic [7:0]  cfg_addr;                                  // Address
  logic [3:0]  cfg_be;                                    // Byte enables
  logic [31:0] cfg_wdata, cfg_rdata, rd_val;              // Data
  logic        cfg_rvalid, card_interface_choice, card_function_off, card_access_en; // Outputs
  logic        power_switch_type, io_base_bit0, io_limit_bit0, general_event_out;   // Outputs
  logic [1:0]  bus_priority_policy;                       // Priority field
  logic [2:0]  arb_policy_onehot;                         // Decoded policy
  logic [4:0]  pins, e;                                   // Pin levels, toggle mask
  logic [15:0] v;                                         // Control value
  int          fails, cmp_count, seed, i;                 // Counters, seed, loop
  assign {multi_terminal_5, multi_terminal_4, multi_terminal_2, multi_terminal_1, multi_terminal_0} = pins;
  gcer_regs gcer_regs_inst (.*);
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Expected control after a host bus reset
  function automatic logic [15:0] after_host(input logic [15:0] c);
    return (c & 16'h5C84) | 16'h0003;
  endfunction : after_host
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Verdict
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // One write cycle
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge ref_clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, b, d};
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask : wr
  // One read cycle, bounded wait for the answer
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(negedge ref_clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    while (cfg_rvalid !== 1'b1 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 3) begin
      fails++;
      finish_test();
    end
    rd_val = cfg_rdata;
  endtask : rd
  // Software event pulse of one cycle
  task automatic pulse(input logic [1:0] p);
    @(negedge ref_clk);
    {sock_power_write, sock_vpp12_change} = p;
    @(negedge ref_clk);
    {sock_power_write, sock_vpp12_change} = 2'h0;
  endtask : pulse
  // Main sequence
  initial begin
    seed = 32'h74CEDD20;
    {arst_n, host_reset_n, cfg_wr, cfg_rd, sock_power_write, sock_vpp12_change} = 6'h10;
    {cfg_addr, cfg_be, cfg_wdata, pins} = 49'h0;
    {route_terminal_5, route_terminal_4, route_terminal_2, route_terminal_1, route_terminal_0} = 20'h0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(8'h84);
    chk(rd_val, 32'h0003_0000);
    for (i = 0; i < 8; i++) begin
      v = {14'($random(seed)), i[1:0]};
      wr(8'h84, 4'hC, {v, 16'h0});
      chk({bus_priority_policy, card_interface_choice, io_limit_bit0, io_base_bit0, power_switch_type, card_function_off},
          {v[1:0], v[14], v[12], v[11], v[10], v[7]});
      chk({arb_policy_onehot, card_access_en}, {3'h1 << (v[1] ? 2 : v[0]), !v[7]});
      rd(8'h86);
      chk(rd_val, {v, 16'h0});
    end
    wr(8'h84, 4'hC, 32'hFFFF_0000);
    host_reset_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    host_reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(8'h84);
    chk(rd_val, {after_host(16'hFFFF), 16'h0});
    wr(8'h88, 4'h3, 32'h0000_FFFF);
    pulse(2'h2);
    chk(general_event_out, 1'b1);
    pulse(2'h1);
    rd(8'h88);
    chk(rd_val, 32'h0000_DFC0);
    sock_power_write = 1'b1;
    wr(8'h88, 4'h1, 32'h0000_00C0);
    sock_power_write = 1'b0;
    rd(8'h88);
    chk(rd_val, 32'h0000_DF80);
    wr(8'h88, 4'h1, 32'h0000_0080);
    chk(general_event_out, 1'b0);
    for (i = 0; i < 6; i++) begin
      route_terminal_5 = i[0] ? 4'h0 : 4'h1;
      e = 5'($random(seed)) | 5'h01;
      pins = pins ^ e;
      repeat (5) @(negedge ref_clk);
      rd(8'h88);
      chk(rd_val, {16'h0, 8'hDF, 3'h0, e & (i[0] ? 5'h1F : 5'h0F)});
      wr(8'h88, 4'h1, 32'h0000_001F);
    end
    wr(8'h88, 4'h2, 32'h0000_0000);
    pulse(2'h2);
    chk(general_event_out, 1'b0);
    wr(8'h88, 4'h2, 32'h0000_4000);
    host_reset_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    host_reset_n = 1'b1;
    rd(8'h88);
    chk(rd_val, 32'h0000_4080);
    arst_n = 1'b0;
    @(negedge ref_clk);
    arst_n = 1'b1;
    rd(8'h84);
    chk(rd_val, 32'h0003_0000);
    rd(8'h88);
    chk(rd_val, 32'h0000_0000);
    finish_test();
  end
endmodule : gcer_regs_tb_top
